// ==== rtl/gxp_regs.vh ====
`ifndef GXP_REGS_VH
`define GXP_REGS_VH

// fixed upper part of the 7-bit slave address
`define GXP_ADDR_FIXED      5'h1d

// register select codes, low three command bits
`define GXP_SEL_PIN0        3'h0
`define GXP_SEL_PIN1        3'h1
`define GXP_SEL_DRIVE0      3'h2
`define GXP_SEL_DRIVE1      3'h3
`define GXP_SEL_INVERT0     3'h4
`define GXP_SEL_INVERT1     3'h5
`define GXP_SEL_DIR0        3'h6
`define GXP_SEL_DIR1        3'h7

// field positions
`define GXP_SEL_MSB         2
`define GXP_SEL_LSB         0
`define GXP_RW_BIT          0

// register group codes, select bits 2..1
`define GXP_GRP_PIN         2'h0
`define GXP_GRP_DRIVE       2'h1
`define GXP_GRP_INVERT      2'h2
`define GXP_GRP_DIR         2'h3

// reset values
`define GXP_RST_DRIVE       8'hff
`define GXP_RST_INVERT      8'h00
`define GXP_RST_DIR         8'hff
`define GXP_RST_POINTER     8'h00

// bits per byte on the link
`define GXP_BYTE_BITS       4'h8
`define GXP_LAST_TX_BIT     4'h7

`endif

// ==== rtl/gxp_sync.v ====
`timescale 1ns/1ps
`default_nettype none

module gxp_sync #(
  parameter WIDTH = 20
) (
  input  wire             sys_clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta_reg;
      reg stable_reg;
      // first stage feeds only the second stage
      always @(posedge sys_clk_i) begin
        if (rst_i) begin
          meta_reg   <= 1'b1;
          stable_reg <= 1'b1;
        end else begin
          meta_reg   <= async_i[g];
          stable_reg <= meta_reg;
        end
      end
      assign sync_o[g] = stable_reg;
    end
  endgenerate

endmodule // gxp_sync

`default_nettype wire

// ==== rtl/gxp_expander.v ====
// What this block does
// - answer slave address 11101 plus the two strap levels
// - eighth address bit one means read, zero means write
// - first byte after a write address becomes the readable pointer
// - three low pointer bits select one of eight registers
// - pointer is only loaded by write transfers, never by read bytes
// - reads keep using the selected pair until a new pointer
// - pin level registers show every pin, input or output
// - writes to pin level registers are acked but change nothing
// - drive bits reach a pin only while it is an output
// - reading drive registers returns the stored flops, not pins
// - invert bit flips the reported level of input pins
// - direction bit one is input with driver off, zero drives
// - reset: drive all ones, invert all zeros, direction all ones
// - write: address, ack, pointer, ack, data bytes, stop
// - pointer toggles to the other pair register per further byte
// - read address is not acked until a pointer has been written
// - repeated start after pointer-only write reads that register
`include "gxp_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module gxp_expander #(
  parameter PORT_W = 8
) (
  input  wire              sys_clk_i,
  input  wire              rst_i,
  input  wire              scl_i,
  input  wire              sda_i,
  output wire              sda_o,
  output wire              sda_oe_o,
  input  wire              addr_strap_lo_i,
  input  wire              addr_strap_hi_i,
  input  wire [PORT_W-1:0] port0_pin_i,
  output wire [PORT_W-1:0] port0_pin_o,
  output wire [PORT_W-1:0] port0_pin_oe_o,
  input  wire [PORT_W-1:0] port1_pin_i,
  output wire [PORT_W-1:0] port1_pin_o,
  output wire [PORT_W-1:0] port1_pin_oe_o
);

  localparam SYNC_W = 2 * PORT_W + 4;

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_RX   = 5'h02;
  localparam [4:0] ST_SACK = 5'h04;
  localparam [4:0] ST_TX   = 5'h08;
  localparam [4:0] ST_MACK = 5'h10;

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisation

  wire [SYNC_W-1:0] sync_vec;
  wire              scl_s;
  wire              sda_s;
  wire              strap_lo_s;
  wire              strap_hi_s;
  wire [PORT_W-1:0] pin0_s;
  wire [PORT_W-1:0] pin1_s;

  gxp_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   ({scl_i, sda_i, addr_strap_lo_i, addr_strap_hi_i,
                 port0_pin_i, port1_pin_i}),
    .sync_o    (sync_vec)
  );

  assign scl_s      = sync_vec[SYNC_W-1];
  assign sda_s      = sync_vec[SYNC_W-2];
  assign strap_lo_s = sync_vec[SYNC_W-3];
  assign strap_hi_s = sync_vec[SYNC_W-4];
  assign pin0_s     = sync_vec[2*PORT_W-1:PORT_W];
  assign pin1_s     = sync_vec[PORT_W-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // link edge and condition detection

  reg  scl_d_reg;
  reg  sda_d_reg;
  wire scl_rise;
  wire scl_fall;
  wire start_cond;
  wire stop_cond;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign scl_rise   = scl_s & ~scl_d_reg;
  assign scl_fall   = ~scl_s & scl_d_reg;
  // both lines sampled through equal delay, so sda moves inside scl high
  assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  ////////////////////////////////////////////////////////////////////////////////
  // register file

  reg [PORT_W-1:0] drive0_reg;
  reg [PORT_W-1:0] drive1_reg;
  reg [PORT_W-1:0] invert0_reg;
  reg [PORT_W-1:0] invert1_reg;
  reg [PORT_W-1:0] dir0_reg;
  reg [PORT_W-1:0] dir1_reg;
  reg [7:0]        pointer_reg;
  reg              pointer_set_reg;

  wire [PORT_W-1:0] level0;
  wire [PORT_W-1:0] level1;

  genvar g;
  generate
    for (g = 0; g < PORT_W; g = g + 1) begin : g_pin
      // inversion only applies to pins set as inputs
      assign level0[g]         = pin0_s[g] ^ (invert0_reg[g] & dir0_reg[g]);
      assign level1[g]         = pin1_s[g] ^ (invert1_reg[g] & dir1_reg[g]);
      assign port0_pin_o[g]    = drive0_reg[g];
      assign port1_pin_o[g]    = drive1_reg[g];
      assign port0_pin_oe_o[g] = ~dir0_reg[g];
      assign port1_pin_oe_o[g] = ~dir1_reg[g];
    end
  endgenerate

  reg [7:0] rd_data;

  always @* begin
    rd_data = 8'h00;
    case (pointer_reg[`GXP_SEL_MSB:`GXP_SEL_LSB])
      `GXP_SEL_PIN0:    rd_data = level0;
      `GXP_SEL_PIN1:    rd_data = level1;
      `GXP_SEL_DRIVE0:  rd_data = drive0_reg;
      `GXP_SEL_DRIVE1:  rd_data = drive1_reg;
      `GXP_SEL_INVERT0: rd_data = invert0_reg;
      `GXP_SEL_INVERT1: rd_data = invert1_reg;
      `GXP_SEL_DIR0:    rd_data = dir0_reg;
      `GXP_SEL_DIR1:    rd_data = dir1_reg;
      default:          rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // link state machine

  reg [4:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] tx_reg;
  reg       rw_reg;
  reg       got_addr_reg;
  reg       got_cmd_reg;
  reg       more_reg;
  reg       sda_oe_reg;

  wire [7:0] rx_byte;
  wire       addr_match;
  wire       wr_strobe;
  wire       byte_done;

  assign rx_byte    = {shift_reg[6:0], sda_s};
  assign byte_done  = (bit_cnt_reg == `GXP_BYTE_BITS);
  assign addr_match = (shift_reg[7:1] == {`GXP_ADDR_FIXED, strap_hi_s, strap_lo_s});
  // a data byte of a write transfer lands in the selected register
  assign wr_strobe  = (state_reg == ST_RX) & scl_fall & byte_done &
                      got_addr_reg & ~rw_reg & got_cmd_reg;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg       <= ST_IDLE;
      bit_cnt_reg     <= 4'h0;
      shift_reg       <= 8'h00;
      tx_reg          <= 8'h00;
      rw_reg          <= 1'b0;
      got_addr_reg    <= 1'b0;
      got_cmd_reg     <= 1'b0;
      more_reg        <= 1'b0;
      sda_oe_reg      <= 1'b0;
      pointer_reg     <= `GXP_RST_POINTER;
      pointer_set_reg <= 1'b0;
    end else if (start_cond) begin
      // a start or repeated start always restarts address reception
      state_reg    <= ST_RX;
      bit_cnt_reg  <= 4'h0;
      got_addr_reg <= 1'b0;
      got_cmd_reg  <= 1'b0;
      sda_oe_reg   <= 1'b0;
    end else if (stop_cond) begin
      state_reg  <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        ST_RX: begin
          if (scl_rise && !byte_done) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && byte_done) begin
            if (!got_addr_reg) begin
              // reads are refused until a pointer exists
              if (addr_match && (!shift_reg[`GXP_RW_BIT] || pointer_set_reg)) begin
                rw_reg       <= shift_reg[`GXP_RW_BIT];
                got_addr_reg <= 1'b1;
                sda_oe_reg   <= 1'b1;
                state_reg    <= ST_SACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end else if (!got_cmd_reg) begin
              pointer_reg     <= shift_reg;
              pointer_set_reg <= 1'b1;
              got_cmd_reg     <= 1'b1;
              sda_oe_reg      <= 1'b1;
              state_reg       <= ST_SACK;
            end else begin
              pointer_reg[`GXP_SEL_LSB] <= ~pointer_reg[`GXP_SEL_LSB];
              sda_oe_reg <= 1'b1;
              state_reg  <= ST_SACK;
            end
          end
        end
        ST_SACK: begin
          if (scl_rise && rw_reg) begin
            // data taken at the ack rising edge, then pointer moves on
            tx_reg                    <= rd_data;
            pointer_reg[`GXP_SEL_LSB] <= ~pointer_reg[`GXP_SEL_LSB];
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              sda_oe_reg <= ~tx_reg[7];
              state_reg  <= ST_TX;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == `GXP_LAST_TX_BIT) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= ST_MACK;
            end else begin
              tx_reg      <= {tx_reg[6:0], 1'b0};
              sda_oe_reg  <= ~tx_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            more_reg <= ~sda_s;
            if (!sda_s) begin
              tx_reg                    <= rd_data;
              pointer_reg[`GXP_SEL_LSB] <= ~pointer_reg[`GXP_SEL_LSB];
            end
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (more_reg) begin
              sda_oe_reg <= ~tx_reg[7];
              state_reg  <= ST_TX;
            end else begin
              // nack ends the read, wait for stop or start
              sda_oe_reg <= 1'b0;
              state_reg  <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg  <= ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register writes

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      drive0_reg  <= `GXP_RST_DRIVE;
      drive1_reg  <= `GXP_RST_DRIVE;
      invert0_reg <= `GXP_RST_INVERT;
      invert1_reg <= `GXP_RST_INVERT;
      dir0_reg    <= `GXP_RST_DIR;
      dir1_reg    <= `GXP_RST_DIR;
    end else if (wr_strobe) begin
      case (pointer_reg[`GXP_SEL_MSB:`GXP_SEL_LSB])
        `GXP_SEL_DRIVE0:  drive0_reg  <= shift_reg;
        `GXP_SEL_DRIVE1:  drive1_reg  <= shift_reg;
        `GXP_SEL_INVERT0: invert0_reg <= shift_reg;
        `GXP_SEL_INVERT1: invert1_reg <= shift_reg;
        `GXP_SEL_DIR0:    dir0_reg    <= shift_reg;
        `GXP_SEL_DIR1:    dir1_reg    <= shift_reg;
        default: begin
          // pin level registers ignore writes
          drive0_reg <= drive0_reg;
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_oe_reg;

endmodule // gxp_expander

`default_nettype wire

// ==== verification/gxp_expander_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module gxp_expander_assertions #(
  parameter PORT_W = 8
) (
  input wire logic              sys_clk_i,
  input wire logic              rst_i,
  input wire logic              scl_i,
  input wire logic              sda_i,
  input wire logic              sda_o,
  input wire logic              sda_oe_o,
  input wire logic              addr_strap_lo_i,
  input wire logic              addr_strap_hi_i,
  input wire logic [PORT_W-1:0] port0_pin_i,
  input wire logic [PORT_W-1:0] port0_pin_o,
  input wire logic [PORT_W-1:0] port0_pin_oe_o,
  input wire logic [PORT_W-1:0] port1_pin_i,
  input wire logic [PORT_W-1:0] port1_pin_o,
  input wire logic [PORT_W-1:0] port1_pin_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  // reset checks override the default disable
  property p_rst_drive;
    disable iff (1'b0) rst_i |=> port0_pin_o == 8'hff && port1_pin_o == 8'hff;
  endproperty
  a_rst_drive: assert property (p_rst_drive) else $error("drive not all ones");
  property p_rst_dir;
    disable iff (1'b0) rst_i |=> port0_pin_oe_o == 8'h00 && port1_pin_oe_o == 8'h00;
  endproperty
  a_rst_dir: assert property (p_rst_dir) else $error("pins driven in reset");
  property p_rst_sda;
    disable iff (1'b0) rst_i |=> !sda_oe_o;
  endproperty
  a_rst_sda: assert property (p_rst_sda) else $error("sda pulled in reset");
  ////////////////////////////////////////////////////////////////////////////
  // port drive and enable outputs and the sda enable only change inside the scl low phase; an sda pull lasts at least three cycles
  property p_drv0;
    $changed(port0_pin_o) && !$past(rst_i) |-> !scl_i;
  endproperty
  a_drv0: assert property (p_drv0) else $error("port0 drive moved");
  property p_drv1;
    $changed(port1_pin_o) && !$past(rst_i) |-> !scl_i;
  endproperty
  a_drv1: assert property (p_drv1) else $error("port1 drive moved");
  property p_dir0;
    $changed(port0_pin_oe_o) && !$past(rst_i) |-> !scl_i;
  endproperty
  a_dir0: assert property (p_dir0) else $error("port0 enable moved");
  property p_dir1;
    $changed(port1_pin_oe_o) && !$past(rst_i) |-> !scl_i;
  endproperty
  a_dir1: assert property (p_dir1) else $error("port1 enable moved");
  property p_sda_edge;
    $changed(sda_oe_o) && !$past(rst_i) |-> !scl_i;
  endproperty
  a_sda_edge: assert property (p_sda_edge) else $error("sda moved, scl high");
  property p_ack_hold;
    $rose(sda_oe_o) |-> sda_oe_o [*3];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("sda pull too short");
endmodule // gxp_expander_assertions

`default_nettype wire

// ==== verification/gxp_i2c_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module gxp_i2c_master_model (
  input  wire logic       clk_i,
  input  wire logic       sda_i,
  output var  logic       scl_o,
  output var  logic       sda_o,
  output var  logic       res_v_o,
  output var  logic [7:0] res_d_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    res_v_o = 1'b0;
    res_d_o = 8'h00;
  end
  task automatic w4();
    repeat (4) @(negedge clk_i);
  endtask
  task automatic put(input logic [7:0] d);
    res_d_o = d;
    res_v_o = 1'b1;
    @(negedge clk_i);
    res_v_o = 1'b0;
  endtask
  // sda moves mid low phase, away from both scl edges
  task automatic bitx(input logic b, output logic r);
    w4();
    sda_o = b;
    w4();
    scl_o = 1'b1;
    w4();
    r = sda_i;
    w4();
    scl_o = 1'b0;
  endtask
  task automatic start();
    w4();
    sda_o = 1'b1;
    w4();
    scl_o = 1'b1;
    w4();
    sda_o = 1'b0;
    w4();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    w4();
    sda_o = 1'b0;
    w4();
    scl_o = 1'b1;
    w4();
    sda_o = 1'b1;
  endtask
  task automatic wbyte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    put({7'h00, ~r});
  endtask
  task automatic rbyte(input logic ack);
    logic [7:0] d;
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(~ack, r);
    put(d);
  endtask
endmodule // gxp_i2c_master_model

`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic       sys_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       st_lo, st_hi, sda_ow, sda_oe, scl, sda_m, res_v;
  logic [7:0] p0_o, p1_o, p0_oe, p1_oe, p0_in, p1_in, res_d;
  logic [7:0] e0, e1, o0, o1, d0, d1, n0, n1, pr, l0, l1;
  logic [6:0] adr;
  logic [2:0] k;
  logic [7:0] exp_q[$];
  integer     error_cnt = 0, samples_checked = 0, seed = 73080, cyc = 0;
  // open drain: the device level only counts while it drives, pull-up otherwise
  wire        sda = sda_m & (sda_oe ? sda_ow : 1'b1);
  assign p0_in = (p0_oe & p0_o) | (~p0_oe & e0);
  assign p1_in = (p1_oe & p1_o) | (~p1_oe & e1);
  always #2.5 sys_clk_i = ~sys_clk_i;
  gxp_expander #(.PORT_W(8)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_ow), .sda_oe_o(sda_oe), .addr_strap_lo_i(st_lo),
    .addr_strap_hi_i(st_hi), .port0_pin_i(p0_in), .port0_pin_o(p0_o), .port0_pin_oe_o(p0_oe),
    .port1_pin_i(p1_in), .port1_pin_o(p1_o), .port1_pin_oe_o(p1_oe));
  gxp_i2c_master_model m (.clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_m),
    .res_v_o(res_v), .res_d_o(res_d));
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (exp_q.size() != 0) error_cnt++;
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp_res(input logic [7:0] got);
    samples_checked++;
    if (exp_q.size() == 0 || got !== exp_q[0]) begin
      error_cnt++;
      $display("[ERR] %0t link result %h", $time, got);
    end
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  endtask
  task automatic chk_pins(input logic [7:0] a, b, c, d);
    samples_checked++;
    if ({p0_o, p1_o, p0_oe, p1_oe} !== {a, b, c, d}) begin
      error_cnt++;
      $display("[ERR] %0t pins %h %h %h %h", $time, p0_o, p1_o, p0_oe, p1_oe);
    end
  endtask
  // result strobe stands from one falling edge to the next, so one rising edge sees it
  always @(posedge sys_clk_i) if (res_v) cmp_res(res_d);
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic [7:0] v, input logic a);
    exp_q.push_back({7'h00, a});
    m.wbyte(v);
  endtask
  // pointer only ever goes out in a write transfer
  task automatic set_ptr(input logic [7:0] p);
    m.start();
    wb({adr, 1'b0}, 1'b1);
    wb(p, 1'b1);
  endtask
  task automatic wr(input logic [7:0] p, v0, v1);
    set_ptr(p);
    wb(v0, 1'b1);
    wb(v1, 1'b1);
    m.stop();
  endtask
  task automatic rd(input int n, input logic [7:0] x0, x1);
    m.start();
    wb({adr, 1'b1}, 1'b1);
    exp_q.push_back(x0);
    m.rbyte(n > 1);
    if (n > 1) begin
      exp_q.push_back(x1);
      m.rbyte(1'b0);
    end
    m.stop();
  endtask
  initial begin
    {st_hi, st_lo} = 2'($random(seed));
    {e0, e1, o0, o1} = $random(seed);
    {d0, d1, n0, n1} = $random(seed);
    pr = 8'($random(seed));
    adr = {5'h1d, st_hi, st_lo};
    repeat (5) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    chk_pins(8'hff, 8'hff, 8'h00, 8'h00);
    m.start();
    wb({adr, 1'b1}, 1'b0);
    m.stop();
    m.start();
    wb({adr ^ 7'h02, 1'b0}, 1'b0);
    m.stop();
    for (k = 3'h1; k < 3'h4; k++) begin
      set_ptr({pr[7:3], k[1:0], 1'b0});
      rd(2, (k == 3'h2) ? 8'h00 : 8'hff, (k == 3'h2) ? 8'h00 : 8'hff);
    end
    wr(8'h06, d0, d1);
    wr(8'h02, o0, o1);
    wr(8'h04, n0, n1);
    chk_pins(o0, o1, ~d0, ~d1);
    wr(8'h00, ~o0, ~o1);
    chk_pins(o0, o1, ~d0, ~d1);
    l0 = ((~d0 & o0) | (d0 & e0)) ^ (n0 & d0);
    l1 = ((~d1 & o1) | (d1 & e1)) ^ (n1 & d1);
    set_ptr(8'h00);
    rd(2, l0, l1);
    rd(1, l0, 8'h00);
    set_ptr(8'h03);
    rd(2, o1, o0);
    set_ptr(8'h05);
    rd(2, n1, n0);
    set_ptr(8'h07);
    rd(2, d1, d0);
    // second reset in mid-run: defaults return and the pointer is forgotten
    rst_i = 1'b1;
    repeat (5) @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    chk_pins(8'hff, 8'hff, 8'h00, 8'h00);
    m.start();
    wb({adr, 1'b1}, 1'b0);
    m.stop();
    tally_and_finish();
  end
endmodule // testbench

bind gxp_expander gxp_expander_assertions #(.PORT_W(PORT_W)) u_chk (.sys_clk_i(sys_clk_i),
  .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .addr_strap_lo_i(addr_strap_lo_i), .addr_strap_hi_i(addr_strap_hi_i),
  .port0_pin_i(port0_pin_i), .port0_pin_o(port0_pin_o), .port0_pin_oe_o(port0_pin_oe_o),
  .port1_pin_i(port1_pin_i), .port1_pin_o(port1_pin_o), .port1_pin_oe_o(port1_pin_oe_o));

`default_nettype wire
